// ==== dv/acs_core_model.sv ====
// Behavioural model of the analog multiplexer and converter core.
// Assumes it sees the registered steering and command outputs of the control block on hclk.
`timescale 1ns/1ns
module acs_core_model (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire acs_pkg::acs_mux_t  mux_in,
   input  wire acs_pkg::acs_core_t core_in,
   output logic [7:0]              n_finish,
   output logic [7:0]              n_abort,
   output logic [7:0]              n_convert,
   output logic [7:0]              n_second
);
   logic [4:0] prev_cmd;
   // Command levels in the order sample, convert, second pass, abort, finish.
   wire  [4:0] cur_cmd = {core_in.sample, core_in.convert, core_in.second_pair,
                          core_in.abort, core_in.finish};
   wire  [4:0] rise    = cur_cmd & ~prev_cmd;

   // The core only counts ended, stopped and paired runs and conversions; the bench judges the totals.
   // Counting rising edges rather than levels counts a pulse that is held too long only once.
   // A conversion counts only after an acquisition on a connected input, since a
   // core that samples an open multiplexer converts nothing useful.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_cmd  <= 5'h00;
         n_finish  <= 8'h00;
         n_abort   <= 8'h00;
         n_convert <= 8'h00;
         n_second  <= 8'h00;
      end else begin
         prev_cmd <= cur_cmd;
         if (rise[0]) n_finish <= n_finish + 8'h01;
         if (rise[1]) n_abort <= n_abort + 8'h01;
         if (rise[3] & prev_cmd[4] & mux_in.connect) n_convert <= n_convert + 8'h01;
         if (rise[2]) n_second <= n_second + 8'h01;
      end
   end
endmodule

// ==== dv/adc_channel_and_stage_control_test.sv ====
// Self-checking bench for the converter control block, with a core model on the far side.
// Assumes the package, the design and the defines header are compiled before this file.
`timescale 1ns/1ns
`include "acs_defines.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
   $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module adc_channel_and_stage_control_test;
   localparam logic [5:0] CODES [0:18] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h13, 6'h14, 6'h1D,
      6'h1E, 6'h27, 6'h28, 6'h29, 6'h2D, 6'h2E, 6'h3A, 6'h3B, 6'h3C, 6'h3D, 6'h3E, 6'h3F};
   logic               hclk = 1'b0;
   logic               hresetn = 1'b0;
   logic [31:0]        haddr = 32'h0000_0000;
   logic [1:0]         htrans = 2'h0;
   logic               hwrite = 1'b0;
   logic [31:0]        hwdata = 32'h0000_0000;
   logic [31:0]        hrdata;
   logic               hreadyout;
   logic               hresp;
   logic               c1_idx = 1'b0;
   logic [1:0]         c1_stg = 2'h0;
   acs_pkg::acs_mux_t  mux;
   acs_pkg::acs_core_t core;
   logic               cflag;
   logic [7:0]         n_fin;
   logic [7:0]         n_abt;
   logic [7:0]         n_cnv;
   logic [7:0]         n_sec;
   int                 n_mismatch = 0;
   int                 n_checks = 0;
   logic [31:0]        r;
   logic [3:0]         seen;
   logic [7:0]         f0;
   logic [7:0]         f1;
   logic [7:0]         f2;

   // A 40 ns clock; the one slave's ready is fed back as the bus ready.
   always #20 hclk = ~hclk;

   acs_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .conv1_sequence_index(c1_idx),
      .conv1_stage_state(c1_stg), .mux_out(mux), .core_out(core), .conv2_complete_flag(cflag));
   acs_core_model i_core (.hclk(hclk), .hresetn(hresetn), .mux_in(mux), .core_in(core),
      .n_finish(n_fin), .n_abort(n_abt), .n_convert(n_cnv), .n_second(n_sec));

   // Bus phases end only on a sampled ready, never after a fixed count.
   task automatic wt();
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask
   task automatic bw(input logic [31:0] a, input logic [31:0] d);
      haddr <= a;
      hwrite <= 1'b1;
      htrans <= 2'h2;
      wt();
      htrans <= 2'h0;
      hwdata <= d;
      wt();
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      haddr <= a;
      hwrite <= 1'b0;
      htrans <= 2'h2;
      wt();
      htrans <= 2'h0;
      wt();
      d = hrdata;
   endtask
   // Polls the status until the run has ended; seen holds stages 1 to 3 and bit 6.
   task automatic poll(input logic want2);
      seen = 4'h0;
      for (int k = 0; k < 80; k++) begin
         rd(`ACS_OFF_STAT, r);
         if (r[6] === 1'b1) seen[0] = 1'b1;
         if (r[5:4] !== 2'h0) seen[r[5:4]] = 1'b1;
         if (r[5:4] === 2'h0 && seen[3] && (!want2 || seen[0])) break;
      end
   endtask
   task automatic t_reset();
      rd(`ACS_OFF_CTRL2, r);
      `CHK(r, 32'h0000_0000)
      rd(`ACS_OFF_STAT, r);
      `CHK(r, 32'h0000_0000)
      rd(`ACS_OFF_EVT, r);
      `CHK(r, 32'h0000_0000)
      rd(`ACS_OFF_CONV1, r);
      `CHK(r, 32'h0000_0000)
      `CHK({hreadyout, hresp}, 2'h2)
   endtask
   task automatic t_conv1();
      c1_idx <= 1'b1;
      c1_stg <= 2'h3;
      rd(`ACS_OFF_STAT, r);
      `CHK(r, 32'h0000_0007)
      c1_stg <= 2'h2;
      bw(`ACS_OFF_STAT, 32'h0000_00FF);
      rd(`ACS_OFF_STAT, r);
      `CHK(r, 32'h0000_0006)
      c1_idx <= 1'b0;
      c1_stg <= 2'h0;
   endtask
   task automatic t_chan();
      logic [5:0] c;
      logic       num;
      for (int i = 0; i < 19; i++) begin
         c = CODES[i];
         num = (c <= 6'h02) || (c >= 6'h14 && c <= 6'h1D) || (c >= 6'h28 && c <= 6'h2D);
         bw(`ACS_OFF_CTRL2, {24'h00_0000, c, 2'h1});
         repeat (2) @(posedge hclk);
         `CHK(mux.fixed_reference_source, c == `ACS_CHS_FIXREF)
         `CHK(mux.temp_indicator, c == `ACS_CHS_TEMP)
         `CHK(mux.positive_reference_input, c == `ACS_CHS_POSITIVE_REFERENCE_INPUT)
         `CHK(mux.connect, num || c == 6'h3F || c == 6'h3D || c == 6'h3B)
         if (num) `CHK(mux.input_index, c)
      end
      bw(`ACS_OFF_CTRL2, {24'h00_0000, 6'h3F, 2'h0});
      repeat (2) @(posedge hclk);
      `CHK({mux.connect, mux.fixed_reference_source}, 2'h0)
   endtask
   task automatic t_single();
      f0 = n_fin;
      f1 = n_cnv;
      f2 = n_sec;
      bw(`ACS_OFF_EVT, 32'h0000_0001);
      bw(`ACS_OFF_CTRL2, {24'h00_0000, 6'h14, 2'h3});
      poll(1'b0);
      `CHK(seen, 4'hE)
      rd(`ACS_OFF_CTRL2, r);
      `CHK(r[1:0], 2'h1)
      rd(`ACS_OFF_EVT, r);
      `CHK(r[0], 1'b1)
      `CHK(cflag, 1'b1)
      `CHK(n_fin, f0 + 8'h01)
      `CHK(n_cnv, f1 + 8'h01)
      `CHK(n_sec, f2)
   endtask
   task automatic t_double();
      f0 = n_fin;
      f1 = n_cnv;
      f2 = n_sec;
      bw(`ACS_OFF_CFG, 32'h0000_0001);
      bw(`ACS_OFF_EVT, 32'h0000_0001);
      bw(`ACS_OFF_CTRL2, {24'h00_0000, 6'h28, 2'h3});
      poll(1'b1);
      `CHK(seen, 4'hF)
      `CHK(r[6], 1'b0)
      rd(`ACS_OFF_CTRL2, r);
      `CHK(r[1], 1'b0)
      rd(`ACS_OFF_EVT, r);
      `CHK(r[0], 1'b1)
      `CHK(cflag, 1'b1)
      `CHK(n_fin, f0 + 8'h01)
      `CHK(n_cnv, f1 + 8'h02)
      `CHK(n_sec, f2 + 8'h01)
      bw(`ACS_OFF_CFG, 32'h0000_0000);
   endtask
   task automatic t_abort();
      f0 = n_abt;
      bw(`ACS_OFF_EVT, 32'h0000_0001);
      bw(`ACS_OFF_CTRL2, {24'h00_0000, 6'h01, 2'h3});
      rd(`ACS_OFF_STAT, r);
      bw(`ACS_OFF_CTRL2, {24'h00_0000, 6'h01, 2'h1});
      rd(`ACS_OFF_CTRL2, r);
      `CHK(r[1:0], 2'h1)
      rd(`ACS_OFF_STAT, r);
      `CHK(r[6:4], 3'h0)
      rd(`ACS_OFF_EVT, r);
      `CHK(r[0], 1'b0)
      `CHK(cflag, 1'b0)
      `CHK(n_abt, f0 + 8'h01)
   endtask
   task automatic t_rc();
      bw(`ACS_OFF_CFG, 32'h0000_0002);
      bw(`ACS_OFF_CTRL2, {24'h00_0000, 6'h3D, 2'h3});
      rd(`ACS_OFF_STAT, r);
      `CHK(r[5:4], 2'h0)
      rd(`ACS_OFF_CTRL2, r);
      `CHK(r[1], 1'b1)
      poll(1'b0);
      `CHK(seen[3], 1'b1)
      bw(`ACS_OFF_CFG, 32'h0000_0000);
   endtask
   task automatic t_off();
      bw(`ACS_OFF_CTRL2, {24'h00_0000, 6'h02, 2'h3});
      rd(`ACS_OFF_STAT, r);
      `CHK(mux.connect, 1'b1)
      bw(`ACS_OFF_CTRL2, {24'h00_0000, 6'h02, 2'h2});
      rd(`ACS_OFF_CTRL2, r);
      `CHK(r[7:0], 8'h08)
      rd(`ACS_OFF_STAT, r);
      `CHK(r[5:4], 2'h0)
      `CHK(mux.connect, 1'b0)
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Main sequence; reset is held for eight cycles before the first transfer.
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_conv1();
      t_chan();
      t_single();
      t_double();
      t_abort();
      t_rc();
      t_off();
      close_out();
   end
   // The tests need under 3000 cycles, so a far longer span means a hang.
   initial begin
      repeat (20000) @(posedge hclk);
      n_mismatch++;
      close_out();
   end
endmodule

// ==== hw/acs_ctrl.sv ====
// Converter-2 control and shared stage-status registers behind an AHB-Lite slave.
// Assumes one AHB-Lite master, whole-word single transfers, converter 1 status from
// logic on hclk, and a converter core that follows the stage commands.
//
// Overview of operation
// RL1: Channel codes 3F, 3D, 3B pick fixed reference, temperature, positive reference.
// RL2: Codes 0-2, 20-29, 40, 41-45 pick numbered inputs; others are reserved.
// RL3: With enable clear, every multiplexer input is disconnected regardless of selection.
// RL4: Writing start with enable set starts a conversion; start reads 1 meanwhile.
// RL5: With the RC conversion clock, the start waits one instruction cycle.
// RL6: Hardware clears the start bit when the conversion finishes.
// RL7: Software clearing start aborts, transfers partial result, sets no completion flag.
// RL8: Enable clear shuts the converter off, disconnects inputs, start reads 0.
// RL9: In double-sample mode start stays set until the second conversion completes.
// RL10: Status bit 6 shows the second result pair in progress, else 0.
// RL11: Status bits 5-4 show 11 convert, 10 acquire, 01 precharge, 00 idle.
// RL12: Converter 1 index at bit 2, stage at bits 1-0; bits 7, 3 zero.
// RL13: Normal completion of a conversion or pair sets the completion flag.
//
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
`include "acs_defines.svh"
module acs_ctrl (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic      [31:0]        hrdata,
   output logic                    hreadyout,
   output logic                    hresp,
   input  wire logic               conv1_sequence_index,
   input  wire logic [1:0]         conv1_stage_state,
   output acs_pkg::acs_mux_t       mux_out,
   output acs_pkg::acs_core_t      core_out,
   output logic                    conv2_complete_flag
);
   localparam logic [7:0] PRE_CYC  = 8'(`ACS_PRE_CYC);
   localparam logic [7:0] ACQ_CYC  = 8'(`ACS_ACQ_CYC);
   localparam logic [7:0] CONV_CYC = 8'(`ACS_CONV_CYC);

   acs_pkg::acs_state_t state;
   acs_pkg::acs_state_t next_state;
   logic [5:0]  chan_sel;
   logic        conv2_enable;
   logic        conv2_start_status;
   logic        conv2_double_sample_enable;
   logic        rc_clock_select;
   logic        conv2_sequence_index;
   logic [7:0]  stage_cnt;
   logic [7:0]  next_cnt;
   logic        next_index;
   logic        ph_write;
   logic [31:0] ph_addr;

   // Address phase capture; the slave never stalls so hreadyout stays high.
   wire addr_take = hsel & hready & htrans[1];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_write <= 1'b0;
         ph_addr  <= 32'h0000_0000;
      end else begin
         ph_write <= addr_take & hwrite;
         ph_addr  <= addr_take ? haddr : ph_addr;
      end
   end

   // Write decode of the data phase.
   wire wr_ctrl = ph_write & (ph_addr == `ACS_OFF_CTRL2);
   wire wr_cfg  = ph_write & (ph_addr == `ACS_OFF_CFG);
   wire wr_evt  = ph_write & (ph_addr == `ACS_OFF_EVT);
   wire wr_go   = hwdata[`ACS_CTRL2_GO_BIT];
   wire wr_en   = hwdata[`ACS_CTRL2_EN_BIT];
   wire busy    = (state != acs_pkg::ACS_IDLE);

   // Start, abort and shut-off events seen by the sequencer.
   wire start_req = wr_ctrl & wr_go & wr_en & ~conv2_start_status; // RL4
   wire abort_req = wr_ctrl & ~wr_go & conv2_start_status; // RL7
   wire shut_req  = wr_ctrl & ~wr_en; // RL8
   wire cnt_done  = (stage_cnt == 8'h01);
   wire last_conv = (state == acs_pkg::ACS_CONV) & cnt_done;
   // Only a pair ends the sequence when double sampling is on.
   wire seq_end   = last_conv & (~conv2_double_sample_enable | conv2_sequence_index); // RL9
   wire stop_now  = abort_req | shut_req;

   // Sequencer: delay with the RC clock, precharge, acquisition, conversion; the last three repeated for a pair.
   always_comb begin
      next_state = state;
      next_cnt   = stage_cnt - 8'h01;
      next_index = conv2_sequence_index;
      unique case (state)
         acs_pkg::ACS_IDLE: begin
            next_cnt = stage_cnt;
            if (start_req & rc_clock_select) begin
               next_state = acs_pkg::ACS_DELAY; // RL5
               next_cnt   = `ACS_INSTR_CYCLES;
            end else if (start_req) begin
               next_state = acs_pkg::ACS_PRE;
               next_cnt   = PRE_CYC;
            end
         end
         acs_pkg::ACS_DELAY: if (cnt_done) begin
            next_state = acs_pkg::ACS_PRE;
            next_cnt   = PRE_CYC;
         end
         acs_pkg::ACS_PRE: if (cnt_done) begin
            next_state = acs_pkg::ACS_ACQ;
            next_cnt   = ACQ_CYC;
         end
         acs_pkg::ACS_ACQ: if (cnt_done) begin
            next_state = acs_pkg::ACS_CONV;
            next_cnt   = CONV_CYC;
         end
         acs_pkg::ACS_CONV: if (cnt_done) begin
            if (seq_end) begin
               next_state = acs_pkg::ACS_IDLE; // RL6
               next_index = 1'b0;
            end else begin
               next_state = acs_pkg::ACS_PRE; // RL9
               next_cnt   = PRE_CYC;
               next_index = 1'b1;
            end
         end
      endcase
      if (stop_now) begin
         next_state = acs_pkg::ACS_IDLE;
         next_index = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state                <= acs_pkg::ACS_IDLE;
         stage_cnt            <= 8'h00;
         conv2_sequence_index <= 1'b0;
      end else begin
         state                <= next_state;
         stage_cnt            <= next_cnt;
         conv2_sequence_index <= next_index; // RL10
      end
   end

   // Control and configuration registers; start reads back busy through the flop.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chan_sel                   <= 6'h00;
         conv2_enable               <= 1'b0;
         conv2_start_status         <= 1'b0;
         conv2_double_sample_enable <= 1'b0;
         rc_clock_select            <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            chan_sel     <= hwdata[`ACS_CTRL2_CHS_MSB:`ACS_CTRL2_CHS_LSB];
            conv2_enable <= wr_en;
         end
         if (wr_cfg) begin
            conv2_double_sample_enable <= hwdata[`ACS_CFG_DSEN_BIT];
            rc_clock_select            <= hwdata[`ACS_CFG_RCCLK_BIT];
         end
         if (stop_now | seq_end)
            conv2_start_status <= 1'b0; // RL6 RL7 RL8
         else if (start_req)
            conv2_start_status <= 1'b1; // RL4
      end
   end

   // Completion flag: set wins over a write-one clear in the same cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         conv2_complete_flag <= 1'b0;
      else if (seq_end & ~stop_now)
         conv2_complete_flag <= 1'b1; // RL13
      else if (wr_evt & hwdata[`ACS_EVT_DONE_BIT])
         conv2_complete_flag <= 1'b0;
   end

   // Channel decode of the multiplexer.
   wire ch_low   = (chan_sel <= 6'h02);
   wire ch_mid   = (chan_sel >= 6'h14) & (chan_sel <= 6'h1D);
   wire ch_high  = (chan_sel >= 6'h28) & (chan_sel <= 6'h2D);
   wire ch_fix   = (chan_sel == `ACS_CHS_FIXREF);
   wire ch_temp  = (chan_sel == `ACS_CHS_TEMP);
   wire ch_positive_reference_input = (chan_sel == `ACS_CHS_POSITIVE_REFERENCE_INPUT);
   wire [5:0] idx_mid  = 6'(chan_sel - 6'h14 + 6'd20);
   wire [5:0] idx_high = 6'(chan_sel - 6'h28 + 6'd40);
   wire [5:0] in_index = ch_low ? chan_sel : (ch_mid ? idx_mid : (ch_high ? idx_high : 6'h00)); // RL2
   wire       num_ok   = ch_low | ch_mid | ch_high;

   // Stage field of converter 2.
   wire [1:0] stg2 = (state == acs_pkg::ACS_CONV) ? `ACS_STG_CONV :
                     (state == acs_pkg::ACS_ACQ)  ? `ACS_STG_ACQ  :
                     (state == acs_pkg::ACS_PRE)  ? `ACS_STG_PRE  : `ACS_STG_IDLE; // RL11
   wire [7:0] stat_val = {1'b0, conv2_sequence_index, stg2, 1'b0,
                          conv1_sequence_index, conv1_stage_state}; // RL12
   wire [7:0] ctrl_val = {chan_sel, conv2_start_status, conv2_enable};

   // Read decode; unmapped offsets read zero with an OKAY response.
   wire [31:0] rd_mux = (haddr == `ACS_OFF_CTRL2) ? {24'h00_0000, ctrl_val} :
                        (haddr == `ACS_OFF_STAT)  ? {24'h00_0000, stat_val} :
                        (haddr == `ACS_OFF_CFG)   ? {30'h0000_0000, rc_clock_select,
                                                     conv2_double_sample_enable} :
                        (haddr == `ACS_OFF_EVT)   ? {31'h0000_0000, conv2_complete_flag} :
                        32'h0000_0000;

   // Registered outputs towards the bus and the analog side.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         mux_out   <= '0;
         core_out  <= '0;
      end else begin
         hrdata    <= (addr_take & ~hwrite) ? rd_mux : hrdata;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         mux_out.connect                  <= conv2_enable & (num_ok | ch_fix | ch_temp | ch_positive_reference_input); // RL3 RL8
         mux_out.input_index              <= in_index;
         mux_out.fixed_reference_source   <= conv2_enable & ch_fix; // RL1
         mux_out.temp_indicator           <= conv2_enable & ch_temp; // RL1
         mux_out.positive_reference_input <= conv2_enable & ch_positive_reference_input; // RL1
         core_out.sample      <= (next_state == acs_pkg::ACS_ACQ);
         core_out.convert     <= (next_state == acs_pkg::ACS_CONV);
         core_out.second_pair <= next_index;
         core_out.abort       <= abort_req & busy; // RL7
         core_out.finish      <= seq_end & ~stop_now;
      end
   end

   // Checks next to the sequencer.
   sequence start_seq;
      start_req & ~rc_clock_select;
   endsequence
   sequence rc_start_seq;
      start_req & rc_clock_select;
   endsequence

   start_pre_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL4
      start_seq |=> conv2_start_status & (stg2 == `ACS_STG_PRE))
      else $error("start did not enter precharge");
   start_delay_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL5
      rc_start_seq |=> (stg2 == `ACS_STG_IDLE) [*4] ##1 (stg2 == `ACS_STG_PRE)
                       or (##[0:3] stop_now))
      else $error("rc start not delayed");
   done_clear_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL6
      seq_end |=> ~conv2_start_status & ~busy)
      else $error("start bit not cleared on finish");
   abort_noflag_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL7
      abort_req & ~conv2_complete_flag |=> ~conv2_complete_flag & ~busy & core_out.abort)
      else $error("abort raised completion");
   mux_off_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL3
      ~conv2_enable |=> ~mux_out.connect & ~mux_out.fixed_reference_source)
      else $error("mux connected while disabled");
   shut_go_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL8
      ~conv2_enable |-> ~conv2_start_status & ~busy)
      else $error("active while disabled");
   pair_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL9
      last_conv & conv2_double_sample_enable & ~conv2_sequence_index & ~stop_now
      |=> conv2_start_status & conv2_sequence_index)
      else $error("pair ended early");
   index_idle_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL10
      ~conv2_start_status |-> ~stat_val[6])
      else $error("index set while idle");
   stage_map_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL11
      (stg2 == `ACS_STG_IDLE) == (~busy | state == acs_pkg::ACS_DELAY))
      else $error("stage field mismatch");
   stat_zero_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL12
      ~stat_val[7] & ~stat_val[3] & (stat_val[1:0] == conv1_stage_state))
      else $error("status bits wrong");
   flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL13
      seq_end & ~stop_now |=> conv2_complete_flag)
      else $error("completion flag not set");
   chan_fix_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL1
      conv2_enable & ch_fix |=> mux_out.fixed_reference_source & mux_out.connect)
      else $error("fixed reference not routed");
   chan_num_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL2
      conv2_enable & (chan_sel == 6'h28) |=> mux_out.input_index == 6'd40)
      else $error("input index wrong");

   // Stage lengths of one pass; only an abort or a shut-off may cut a stage short.
   // Long stages are split into short repetitions so that the checks stay cheap.
   sequence pre_run_seq;
      (stg2 == `ACS_STG_PRE) [*5] ##1 (stg2 == `ACS_STG_ACQ);
   endsequence
   sequence acq_run_seq;
      (stg2 == `ACS_STG_ACQ) [*8] ##1 (stg2 == `ACS_STG_ACQ) [*2]
      ##1 (stg2 == `ACS_STG_CONV);
   endsequence
   sequence conv_run_seq;
      (stg2 == `ACS_STG_CONV) [*6] ##1 (stg2 == `ACS_STG_CONV) [*6]
      ##1 (stg2 != `ACS_STG_CONV);
   endsequence
   pre_len_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL11
      $rose(stg2 == `ACS_STG_PRE) |-> pre_run_seq or (##[0:4] stop_now))
      else $error("precharge length wrong");
   acq_len_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL11
      $rose(stg2 == `ACS_STG_ACQ) |-> acq_run_seq or (##[0:9] stop_now))
      else $error("acquisition length wrong");
   conv_len_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL11
      $rose(stg2 == `ACS_STG_CONV) |-> conv_run_seq or (##[0:11] stop_now))
      else $error("conversion length wrong");

   // Pulses towards the core last one cycle, and a finish leaves the sequencer at rest.
   abort_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL7
      core_out.abort |=> ~core_out.abort)
      else $error("abort pulse held");
   finish_rest_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL6
      core_out.finish |-> ~conv2_start_status & ~busy & ~core_out.sample)
      else $error("finish while running");

   // The second pass begins with a fresh precharge and tells the core so.
   index_pre_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL10
      $rose(conv2_sequence_index) |-> (stg2 == `ACS_STG_PRE) & core_out.second_pair)
      else $error("second pass started wrong");

   // A write of one clears the flag unless a completion lands in the same cycle.
   flag_clear_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL13
      wr_evt & hwdata[`ACS_EVT_DONE_BIT] & ~seq_end |=> ~conv2_complete_flag)
      else $error("completion flag not cleared");

   // Reserved codes stay open; the other internal sources are routed when enabled.
   chan_rsvd_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL2
      ~num_ok & ~ch_fix & ~ch_temp & ~ch_positive_reference_input |=> ~mux_out.connect)
      else $error("reserved code connected");
   chan_temp_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL1
      conv2_enable & ch_temp |=> mux_out.temp_indicator & mux_out.connect)
      else $error("temperature source not routed");
   chan_vref_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL1
      conv2_enable & ch_positive_reference_input |=> mux_out.positive_reference_input & mux_out.connect)
      else $error("positive reference not routed");

   // The sample and convert commands to the core follow the reported stage cycle for cycle.
   core_cmd_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL11
      (core_out.convert == (stg2 == `ACS_STG_CONV)) &
      (core_out.sample == (stg2 == `ACS_STG_ACQ)))
      else $error("core commands out of step");

   // Read data change only on a read address phase; the slave never waits or errs.
   rdata_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ~(addr_take & ~hwrite) |=> $stable(hrdata))
      else $error("read data changed without a read");
   bus_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
      hreadyout & ~hresp)
      else $error("slave stalled or erred");
endmodule

// ==== hw/acs_defines.svh ====
// Register offsets, field positions, reset values and stage timing counts of the
// converter control block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

`define ACS_OFF_CTRL2        32'h0000_0000
`define ACS_OFF_STAT         32'h0000_0004
`define ACS_OFF_CFG          32'h0000_0008
`define ACS_OFF_EVT          32'h0000_000C
`define ACS_OFF_CONV1        32'h0000_0010

`define ACS_CTRL2_RESET      8'h00
`define ACS_STAT_RESET       8'h00
`define ACS_CTRL2_EN_BIT     0
`define ACS_CTRL2_GO_BIT     1
`define ACS_CTRL2_CHS_LSB    2
`define ACS_CTRL2_CHS_MSB    7
`define ACS_CFG_DSEN_BIT     0
`define ACS_CFG_RCCLK_BIT    1
`define ACS_EVT_DONE_BIT     0

`define ACS_CHS_FIXREF       6'h3F
`define ACS_CHS_TEMP         6'h3D
`define ACS_CHS_POSITIVE_REFERENCE_INPUT        6'h3B

`define ACS_STG_IDLE         2'h0
`define ACS_STG_PRE          2'h1
`define ACS_STG_ACQ          2'h2
`define ACS_STG_CONV         2'h3

`define ACS_CLK_MHZ          25
`define ACS_PRE_NS           200
`define ACS_ACQ_NS           400
`define ACS_CONV_NS          480
`define ACS_INSTR_CYCLES     8'h04
`define ACS_PRE_CYC          ((`ACS_PRE_NS * `ACS_CLK_MHZ + 999) / 1000)
`define ACS_ACQ_CYC          ((`ACS_ACQ_NS * `ACS_CLK_MHZ + 999) / 1000)
`define ACS_CONV_CYC         ((`ACS_CONV_NS * `ACS_CLK_MHZ + 999) / 1000)

`endif

// ==== hw/acs_pkg.sv ====
// Types shared by the converter control block.
// Assumes the defines header is on the include path.
`include "acs_defines.svh"
package acs_pkg;
   typedef enum logic [4:0] {
      ACS_IDLE  = 5'b00001,
      ACS_DELAY = 5'b00010,
      ACS_PRE   = 5'b00100,
      ACS_ACQ   = 5'b01000,
      ACS_CONV  = 5'b10000
   } acs_state_t;

   // Analog multiplexer steering towards the converter core.
   typedef struct packed {
      logic       connect;
      logic [5:0] input_index;
      logic       fixed_reference_source;
      logic       temp_indicator;
      logic       positive_reference_input;
   } acs_mux_t;

   // Sampling commands towards the converter core.
   typedef struct packed {
      logic sample;
      logic convert;
      logic second_pair;
      logic abort;
      logic finish;
   } acs_core_t;
endpackage
